/* File: pkg/xform_regs.svh */
// register offsets, field positions, reset values and timing counts of the transform engine
`ifndef XFORM_REGS_SVH
`define XFORM_REGS_SVH

`define XF_OFS_INSTR 5'h00
`define XF_OFS_STATUS 5'h04
`define XF_OFS_BLK 5'h08
`define XF_OFS_PEN 5'h0C

`define XF_OPC_FULL 8'h5E
`define XF_OPC_CUR 8'h1E
`define XF_ROT_HI 15
`define XF_ROT_LO 14
`define XF_MIR_BIT 13
`define XF_CMB_HI 10
`define XF_CMB_LO 8
`define XF_AM_REL_BIT 14
`define XF_OFS_MSB 13

`define XF_ST_BUSY 0
`define XF_ST_ERR 1
`define XF_ST_FULL 2

`define XF_BLK_RST 16'h0000
`define XF_PEN_RST 16'h0000

`define XF_SETUP_FULL 8'h99
`define XF_SETUP_CUR 8'h67
`define XF_PIX_CYC 8'h25
`define XF_PIX_CYC_Z4 8'h18
`define XF_ZOOM4 17'h00004
`define XF_ZOOM_MAX 17'h10000

`define XF_CMB_COPY 3'h0
`define XF_CMB_OR 3'h1
`define XF_CMB_AND 3'h2
`define XF_CMB_XOR 3'h3
`define XF_CMB_ZERO 3'h4
`define XF_CMB_ANDN 3'h5
`define XF_CMB_ORN 3'h6
`define XF_CMB_XNOR 3'h7

`endif

/* File: pkg/xform_pkg.sv */
// types shared by the transform engine and its write buffer
package xform_pkg;
   typedef logic [15:0] coord_t;
   typedef logic [16:0] zoom_t;
   typedef enum logic [3:0] {
      ST_IDLE, ST_GSX, ST_GSY, ST_GDX, ST_GDY, ST_GZX, ST_GZY, ST_SETUP,
      ST_RD_SRC, ST_WT_SRC, ST_RD_DST, ST_WT_DST, ST_WR, ST_PACE, ST_DONE
   } state_t;
endpackage

/* File: pkg/pix_if.sv */
// pixel write channel between the engine and its write buffer
`timescale 1ns/1ps
interface pix_if #(parameter int PW = 4);
   import xform_pkg::*;
   logic valid;
   logic ready;
   coord_t x;
   coord_t y;
   logic [PW-1:0] data;
   modport src (output valid, output x, output y, output data, input ready);
   modport snk (input valid, input x, input y, input data, output ready);
endinterface

/* File: logic/pix_fifo.sv */
// small fifo holding combined pixels on their way to display memory
`timescale 1ns/1ps
module pix_fifo #(
   parameter int PW = 4,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   pix_if.snk in,
   output logic out_valid,
   input wire logic out_ready,
   output xform_pkg::coord_t out_x,
   output xform_pkg::coord_t out_y,
   output logic [PW-1:0] out_data
);
   import xform_pkg::*;
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int WW = 32 + PW;

   logic [WW-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0] cnt_q;
   logic push, pop;

   // ready falls honestly when every entry is taken, stalling the engine
   assign in.ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push = in.valid && in.ready;
   assign pop = out_valid && out_ready;
   assign {out_y, out_x, out_data} = mem_q[rp_q];

   // storage has no reset; only pointers and count carry control state
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= {in.y, in.x, in.data};
      end
   end

   // pointer and occupancy bookkeeping
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   no_overflow_a: assert property (@(posedge clk) disable iff (!rst_n)
      cnt_q == (AW+1)'(DEPTH) && !out_ready |=> cnt_q == (AW+1)'(DEPTH))
      else $error("buffer took a word while full");
   cover_full_c: cover property (@(posedge clk) disable iff (!rst_n)
      cnt_q == (AW+1)'(DEPTH) && in.valid);
endmodule

/* File: logic/xform_engine.sv */
// block transform engine: instruction intake, address resolution, pixel walk, combine
//
// Behaviour
// R1: rotation select 00/01/10/11: none, 90, 180, 270 ccw
// R2: mirror flag reflects source left to right about its vertical centre line
// R3: mirror first, then rotation, then zoom
// R4: three-bit combine op merges pixel with destination
// R5: source size comes from earlier block size setting
// R6: full form source pair, relative to pen
// R7: full form relative destination offsets from resolved source
// R8: current form uses pen as source corner
// R9: zoom words x then y, one means unity
// R10: pen moves to destination when done
// R11: full form 153 setup, 37 or 24 per pixel
// R12: current form 103 setup, same pixel costs
// R13: each address pair is two stream words
// R14: host sends opcode, pairs, zoom x, zoom y
`timescale 1ns/1ps
`include "xform_regs.svh"
module xform_engine #(
   parameter int PLANES = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic rq_valid,
   input wire logic rq_ready,
   output xform_pkg::coord_t rq_x,
   output xform_pkg::coord_t rq_y,
   input wire logic rs_valid,
   input wire logic [PLANES-1:0] rs_data,
   output logic wr_valid,
   input wire logic wr_ready,
   output xform_pkg::coord_t wr_x,
   output xform_pkg::coord_t wr_y,
   output logic [PLANES-1:0] wr_data,
   output logic busy
);
   import xform_pkg::*;

   state_t st_q;
   logic full_q, mir_q, rel_q, last_q, err_q, rd_done_q;
   logic [1:0] rot_q;
   logic [2:0] cmb_q;
   coord_t pen_x_q, pen_y_q, blk_w_q, blk_h_q;
   coord_t src_x_q, src_y_q, dst_x_q, dst_y_q, offx_q;
   coord_t u_q, v_q, col_q, row_q, rq_x_q, rq_y_q, out_x_q, out_y_q;
   zoom_t zx_q, zy_q, px_q, py_q;
   logic [7:0] cnt_q;
   logic [PLANES-1:0] sp_q, out_d_q;
   pix_if #(.PW(PLANES)) pix ();

   logic instr_wr, word_ok, take, push, setup_ok, pace_ok, col_end, row_end, empty;
   logic [15:0] w;
   coord_t woff, rw, rh;
   logic [31:0] sof;
   logic [7:0] setup_len, per_pix;

   // source offset for rotated-image cell (u,v): undo rotation, then undo mirror
   function automatic logic [31:0] src_ofs(input coord_t u, input coord_t v,
         input coord_t bw, input coord_t bh, input logic [1:0] rotation_select, input logic mir);
      coord_t mx, my;
      unique case (rotation_select)
         2'h0: begin mx = u; my = v; end // R1
         2'h1: begin mx = bw - 16'h0001 - v; my = u; end // R1
         2'h2: begin mx = bw - 16'h0001 - u; my = bh - 16'h0001 - v; end // R1
         2'h3: begin mx = v; my = bh - 16'h0001 - u; end // R1
      endcase
      // reflection applies to the unrotated image, so it is undone last
      if (mir) mx = bw - 16'h0001 - mx; // R2 R3
      return {my, mx};
   endfunction

   // merge of a source pixel into the destination pixel
   function automatic logic [PLANES-1:0] combine(input logic [2:0] op,
         input logic [PLANES-1:0] s, input logic [PLANES-1:0] d);
      unique case (op)
         `XF_CMB_COPY: return s;
         `XF_CMB_OR: return s | d;
         `XF_CMB_AND: return s & d;
         `XF_CMB_XOR: return s ^ d;
         `XF_CMB_ZERO: return '0;
         `XF_CMB_ANDN: return d & ~s;
         `XF_CMB_ORN: return d | ~s;
         `XF_CMB_XNOR: return ~(s ^ d);
      endcase
   endfunction

   // instruction words arrive as writes to the instruction register
   assign instr_wr = avs_write && (avs_address == `XF_OFS_INSTR);
   assign word_ok = (st_q inside {ST_IDLE, ST_GSX, ST_GSY, ST_GDX, ST_GDY, ST_GZX, ST_GZY});
   assign take = instr_wr && word_ok;
   assign w = avs_writedata[15:0];
   // address words carry a signed 14-bit coordinate or displacement
   assign woff = {{2{w[`XF_OFS_MSB]}}, w[`XF_OFS_MSB:0]}; // R13
   // stalling the word keeps the stream in order while a transform runs
   assign avs_waitrequest = (instr_wr && !word_ok) || (avs_read && !rd_done_q);

   // derived geometry and pacing
   assign rw = rot_q[0] ? blk_h_q : blk_w_q; // R1
   assign rh = rot_q[0] ? blk_w_q : blk_h_q; // R1
   assign empty = (blk_w_q == '0) || (blk_h_q == '0); // R5
   assign setup_len = full_q ? `XF_SETUP_FULL : `XF_SETUP_CUR; // R11 R12
   assign per_pix = (zx_q == `XF_ZOOM4 && zy_q == `XF_ZOOM4) ? `XF_PIX_CYC_Z4 : `XF_PIX_CYC;
   assign setup_ok = (st_q == ST_SETUP) && (cnt_q == setup_len - 8'h01); // R11 R12
   assign pace_ok = (st_q == ST_PACE) && (cnt_q >= per_pix - 8'h01); // R11
   assign push = pix.valid && pix.ready;
   assign col_end = (px_q == zx_q - 17'h00001) && (u_q == rw - 16'h0001);
   assign row_end = (py_q == zy_q - 17'h00001) && (v_q == rh - 16'h0001);
   assign sof = src_ofs(u_q, v_q, blk_w_q, blk_h_q, rot_q, mir_q); // R3

   assign pix.valid = (st_q == ST_WR);
   assign pix.x = out_x_q;
   assign pix.y = out_y_q;
   assign pix.data = out_d_q;
   assign rq_valid = (st_q == ST_RD_SRC) || (st_q == ST_RD_DST);
   assign rq_x = rq_x_q;
   assign rq_y = rq_y_q;
   assign busy = (st_q != ST_IDLE);

   // sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
      end else begin
         unique case (st_q)
            ST_IDLE: if (take) begin
               if (w[7:0] == `XF_OPC_FULL) st_q <= ST_GSX; // R14
               else if (w[7:0] == `XF_OPC_CUR) st_q <= ST_GDX; // R8 R14
            end
            ST_GSX: if (take) st_q <= ST_GSY; // R13
            ST_GSY: if (take) st_q <= ST_GDX; // R13
            ST_GDX: if (take) st_q <= ST_GDY; // R13
            ST_GDY: if (take) st_q <= ST_GZX;
            ST_GZX: if (take) st_q <= ST_GZY; // R9
            ST_GZY: if (take) st_q <= ST_SETUP; // R9
            ST_SETUP: if (setup_ok) st_q <= empty ? ST_DONE : ST_RD_SRC;
            ST_RD_SRC: if (rq_ready) st_q <= ST_WT_SRC;
            ST_WT_SRC: if (rs_valid) st_q <= ST_RD_DST;
            ST_RD_DST: if (rq_ready) st_q <= ST_WT_DST;
            ST_WT_DST: if (rs_valid) st_q <= ST_WR;
            ST_WR: if (pix.ready) st_q <= ST_PACE;
            ST_PACE: if (pace_ok) st_q <= last_q ? ST_DONE : ST_RD_SRC;
            ST_DONE: st_q <= ST_IDLE;
         endcase
      end
   end

   // opcode fields and resolved corners
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         full_q <= 1'b0;
         rot_q <= 2'h0;
         mir_q <= 1'b0;
         cmb_q <= 3'h0;
         rel_q <= 1'b0;
         offx_q <= '0;
         {src_x_q, src_y_q, dst_x_q, dst_y_q} <= '0;
         zx_q <= 17'h00001;
         zy_q <= 17'h00001;
      end else if (take) begin
         unique case (st_q)
            ST_IDLE: begin
               full_q <= (w[7:0] == `XF_OPC_FULL);
               rot_q <= w[`XF_ROT_HI:`XF_ROT_LO]; // R1
               mir_q <= w[`XF_MIR_BIT]; // R2
               cmb_q <= w[`XF_CMB_HI:`XF_CMB_LO]; // R4
               src_x_q <= pen_x_q; // R8
               src_y_q <= pen_y_q; // R8
            end
            ST_GSX, ST_GDX: begin
               rel_q <= w[`XF_AM_REL_BIT];
               offx_q <= woff;
            end
            ST_GSY: begin
               src_x_q <= rel_q ? pen_x_q + offx_q : offx_q; // R6
               src_y_q <= rel_q ? pen_y_q + woff : woff; // R6
            end
            ST_GDY: begin
               // full form offsets from the resolved source, current form from the pen
               dst_x_q <= rel_q ? src_x_q + offx_q : offx_q; // R7 R8
               dst_y_q <= rel_q ? src_y_q + woff : woff; // R7 R8
            end
            ST_GZX: zx_q <= (w == 16'h0000) ? `XF_ZOOM_MAX : {1'b0, w}; // R9
            ST_GZY: zy_q <= (w == 16'h0000) ? `XF_ZOOM_MAX : {1'b0, w}; // R9
            default: ;
         endcase
      end
   end

   // setup and per-pixel cycle counter, saturating so a slow memory cannot wrap it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
      end else if ((st_q == ST_GZY && take) || setup_ok || pace_ok) begin
         cnt_q <= 8'h00; // R11 R12
      end else if (cnt_q != 8'hFF) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // destination raster walk; each rotated cell repeats zoom x by zoom y times
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {u_q, v_q, col_q, row_q} <= '0;
         px_q <= '0;
         py_q <= '0;
         last_q <= 1'b0;
      end else if (st_q == ST_GZY && take) begin
         // cleared before setup, so the first source address already sees cell (0,0)
         {u_q, v_q, col_q, row_q} <= '0;
         px_q <= '0;
         py_q <= '0;
         last_q <= 1'b0;
      end else if (push) begin
         last_q <= col_end && row_end;
         if (col_end) begin
            u_q <= '0;
            px_q <= '0;
            col_q <= '0;
            row_q <= row_q + 16'h0001;
            if (py_q == zy_q - 17'h00001) begin // R9
               py_q <= '0;
               v_q <= v_q + 16'h0001;
            end else begin
               py_q <= py_q + 17'h00001;
            end
         end else begin
            col_q <= col_q + 16'h0001;
            if (px_q == zx_q - 17'h00001) begin // R9
               px_q <= '0;
               u_q <= u_q + 16'h0001;
            end else begin
               px_q <= px_q + 17'h00001;
            end
         end
      end
   end

   // memory addresses and the combined pixel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {rq_x_q, rq_y_q, out_x_q, out_y_q} <= '0;
         sp_q <= '0;
         out_d_q <= '0;
      end else begin
         if (st_q == ST_SETUP || st_q == ST_PACE) begin
            rq_x_q <= src_x_q + sof[15:0]; // R3
            rq_y_q <= src_y_q + sof[31:16]; // R3
         end else if (st_q == ST_WT_SRC && rs_valid) begin
            sp_q <= rs_data;
            rq_x_q <= dst_x_q + col_q;
            rq_y_q <= dst_y_q + row_q;
         end else if (st_q == ST_WT_DST && rs_valid) begin
            out_d_q <= combine(cmb_q, sp_q, rs_data); // R4
            out_x_q <= rq_x_q;
            out_y_q <= rq_y_q;
         end
      end
   end

   // pen position: software may set it only while idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pen_x_q <= `XF_PEN_RST;
         pen_y_q <= `XF_PEN_RST;
      end else if (st_q == ST_DONE) begin
         pen_x_q <= dst_x_q; // R10
         pen_y_q <= dst_y_q; // R10
      end else if (!busy && avs_write && avs_address == `XF_OFS_PEN) begin
         if (avs_byteenable[0]) pen_x_q[7:0] <= avs_writedata[7:0];
         if (avs_byteenable[1]) pen_x_q[15:8] <= avs_writedata[15:8];
         if (avs_byteenable[2]) pen_y_q[7:0] <= avs_writedata[23:16];
         if (avs_byteenable[3]) pen_y_q[15:8] <= avs_writedata[31:24];
      end
   end

   // block size, held stable while a transform uses it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blk_w_q <= `XF_BLK_RST;
         blk_h_q <= `XF_BLK_RST;
      end else if (!busy && avs_write && avs_address == `XF_OFS_BLK) begin
         if (avs_byteenable[0]) blk_w_q[7:0] <= avs_writedata[7:0]; // R5
         if (avs_byteenable[1]) blk_w_q[15:8] <= avs_writedata[15:8];
         if (avs_byteenable[2]) blk_h_q[7:0] <= avs_writedata[23:16];
         if (avs_byteenable[3]) blk_h_q[15:8] <= avs_writedata[31:24];
      end
   end

   // sticky error on an unknown opcode; a new error wins over the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         err_q <= 1'b0;
      end else if (st_q == ST_IDLE && take && w[7:0] != `XF_OPC_FULL
            && w[7:0] != `XF_OPC_CUR) begin
         err_q <= 1'b1;
      end else if (avs_write && avs_address == `XF_OFS_STATUS && avs_byteenable[0]
            && avs_writedata[`XF_ST_ERR]) begin
         err_q <= 1'b0;
      end
   end

   // reads take one wait cycle so read data comes from a flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_done_q <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else begin
         rd_done_q <= avs_read && !rd_done_q;
         if (avs_read && !rd_done_q) begin
            unique case (avs_address)
               `XF_OFS_STATUS: avs_readdata <= {29'h0, full_q, err_q, busy};
               `XF_OFS_BLK: avs_readdata <= {blk_h_q, blk_w_q};
               `XF_OFS_PEN: avs_readdata <= {pen_y_q, pen_x_q};
               default: avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   pix_fifo #(.PW(PLANES), .DEPTH(2)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in(pix.snk),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_x(wr_x),
      .out_y(wr_y),
      .out_data(wr_data)
   );

   // helper counters for timing checks
   logic [8:0] hc_q, gap_q;
   logic first_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hc_q <= '0;
         gap_q <= '0;
         first_q <= 1'b1;
      end else begin
         hc_q <= (st_q == ST_GZY && take) ? 9'h000 : hc_q + {8'h00, hc_q != 9'h1FF};
         gap_q <= (st_q == ST_RD_SRC && st_q != $past(st_q)) ? 9'h001
            : gap_q + {8'h00, gap_q != 9'h1FF};
         if (setup_ok) first_q <= 1'b1;
         else if (st_q == ST_RD_SRC) first_q <= 1'b0;
      end
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);

   setup_time_a: assert property ($rose(rq_valid) && st_q == ST_RD_SRC && first_q
      |-> hc_q == {1'b0, setup_len}) else $error("setup length wrong"); // R11 R12
   pixel_pace_a: assert property (st_q == ST_RD_SRC && $past(st_q) == ST_PACE
      |-> gap_q >= {1'b0, per_pix}) else $error("pixel paced too fast"); // R11
   rot_quarter_a: assert property (st_q == ST_SETUP && rot_q == 2'h1 && !mir_q && u_q == '0
      && v_q == '0 |=> rq_x_q == src_x_q + blk_w_q - 16'h0001) else $error("rotation"); // R1
   mirror_copy_a: assert property (st_q == ST_PACE && rot_q == 2'h0 && mir_q
      |=> rq_x_q == src_x_q + blk_w_q - 16'h0001 - $past(u_q)) else $error("mirror"); // R2 R3
   combine_xor_a: assert property (st_q == ST_WT_DST && rs_valid && cmb_q == `XF_CMB_XOR
      |=> out_d_q == ($past(sp_q) ^ $past(rs_data))) else $error("combine"); // R4
   full_dst_a: assert property (st_q == ST_GDY && take && full_q && rel_q
      |=> dst_x_q == src_x_q + $past(offx_q)) else $error("relative destination"); // R7
   cur_src_a: assert property (st_q == ST_IDLE && take && w[7:0] == `XF_OPC_CUR
      |=> src_x_q == $past(pen_x_q) && src_y_q == $past(pen_y_q)) else $error("pen src"); // R8
   zoom_max_a: assert property (st_q == ST_GZX && take && w == 16'h0000
      |=> zx_q == `XF_ZOOM_MAX) else $error("zoom decode"); // R9
   pen_done_a: assert property (st_q == ST_DONE |=> pen_x_q == $past(dst_x_q)
      && pen_y_q == $past(dst_y_q) && !busy) else $error("pen not at destination"); // R10

   full_done_c: cover property (st_q == ST_DONE && full_q);
   cur_done_c: cover property (st_q == ST_DONE && !full_q);
   rot_mirror_c: cover property (st_q == ST_WR && mir_q && rot_q == 2'h3);
   stall_c: cover property (st_q == ST_WR && !pix.ready);
endmodule

/* File: tb/mem_model.sv */
// display memory model answering the engine's pixel reads and writes
`timescale 1ns/1ps
module mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic rq_valid,
   output logic rq_ready,
   input wire xform_pkg::coord_t rq_x,
   input wire xform_pkg::coord_t rq_y,
   output logic rs_valid,
   output logic [3:0] rs_data,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire xform_pkg::coord_t wr_x,
   input wire xform_pkg::coord_t wr_y,
   input wire logic [3:0] wr_data
);
   import xform_pkg::*;
   logic [3:0] mem [64][64];
   logic pend_q, tick_q;
   logic [5:0] ax_q, ay_q;
   // slow mode grants every other cycle; pixels come too far apart for the write buffer to fill
   assign rq_ready = !slow || tick_q;
   assign wr_ready = !slow || !tick_q;
   // one answer per taken read, two cycles later; idle data toggles so stale values never match
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 1'b0;
         tick_q <= 1'b0;
         rs_valid <= 1'b0;
         rs_data <= 4'h0;
      end else begin
         tick_q <= !tick_q;
         rs_valid <= 1'b0;
         rs_data <= ~rs_data;
         if (rq_valid && rq_ready) begin
            pend_q <= 1'b1;
            ax_q <= rq_x[5:0];
            ay_q <= rq_y[5:0];
         end else if (pend_q) begin
            pend_q <= 1'b0;
            rs_valid <= 1'b1;
            rs_data <= mem[ax_q][ay_q];
         end
      end
   end
   // pixel store; no reset, the bench preloads it
   always @(posedge clk) begin
      if (wr_valid && wr_ready) mem[wr_x[5:0]][wr_y[5:0]] <= wr_data;
   end
endmodule

/* File: tb/block_transform_engine_tb.sv */
// self-checking bench for the block transform engine
`timescale 1ns/1ps
`include "xform_regs.svh"
module block_transform_engine_tb;
   import xform_pkg::*;
   logic clk, rst_n, slow, avs_read, avs_write, avs_waitrequest;
   logic rq_valid, rq_ready, rs_valid, wr_valid, wr_ready, busy, rq_prev;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] rs_data, wr_data;
   coord_t rq_x, rq_y, wr_x, wr_y;
   int err_count, cmp_count, cyc, t_take, bw, bh;
   int rise[$];

   xform_engine #(.PLANES(4)) xform_engine_inst (.clk(clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rq_valid(rq_valid), .rq_ready(rq_ready),
      .rq_x(rq_x), .rq_y(rq_y), .rs_valid(rs_valid), .rs_data(rs_data),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_x(wr_x), .wr_y(wr_y),
      .wr_data(wr_data), .busy(busy));
   mem_model mem_model_inst (.clk(clk), .rst_n(rst_n), .slow(slow), .rq_valid(rq_valid),
      .rq_ready(rq_ready), .rq_x(rq_x), .rq_y(rq_y), .rs_valid(rs_valid),
      .rs_data(rs_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_x(wr_x),
      .wr_y(wr_y), .wr_data(wr_data));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // cycle count and read-request rise stamps for timing checks
   always @(posedge clk) begin
      cyc <= cyc + 1;
      rq_prev <= rq_valid;
      // request rose just after the previous edge
      if (rq_valid && !rq_prev) rise.push_back(cyc - 1);
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // bus cycles hold the request until waitrequest is seen low
   task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      t_take = cyc;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [3:0] pat(input int x, input int y);
      return 4'((x * 3 + y * 5) % 16);
   endfunction
   function automatic logic [3:0] comb(input logic [2:0] op, input logic [3:0] s, d);
      case (op)
         3'h0: return s;
         3'h1: return d | s;
         3'h2: return d & s;
         3'h3: return d ^ s;
         3'h4: return 4'h0;
         3'h5: return d & ~s;
         3'h6: return d | ~s;
         default: return ~(d ^ s);
      endcase
   endfunction

   // run one transform and judge timing, image and pen; words: src x,y, dst x,y, zoom x,y
   task automatic xform(input bit full, input logic [1:0] rotation_select, input logic mir,
         input logic [2:0] op, input logic [15:0] w[6], input int sx, sy, dx, dy, zx, zy);
      int k, x, y, u, v;
      logic [3:0] e;
      for (x = 0; x < 64; x++)
         for (y = 0; y < 64; y++) mem_model_inst.mem[x][y] = pat(x, y);
      bus_wr(`XF_OFS_BLK, {16'(bh), 16'(bw)});
      rise.delete();
      bus_wr(`XF_OFS_INSTR,
         {16'h0, rotation_select, mir, 2'b00, op, full ? `XF_OPC_FULL : `XF_OPC_CUR});
      for (k = full ? 0 : 2; k < 6; k++) bus_wr(`XF_OFS_INSTR, {16'h0, w[k]});
      for (k = 0; k < 40000 && (busy !== 1'b0 || wr_valid !== 1'b0); k++) @(posedge clk);
      chk(busy, 1'b0);
      chk(rise[0] - t_take, full ? 153 : 103);
      if (!slow && rise.size() > 2) chk(rise[2] - rise[0], (zx == 4 && zy == 4) ? 24 : 37);
      for (int i = 0; i < (rotation_select[0] ? bh : bw) * zx; i++)
         for (int j = 0; j < (rotation_select[0] ? bw : bh) * zy; j++) begin
            u = i / zx;
            v = j / zy;
            case (rotation_select)
               2'b00: begin x = u; y = v; end
               2'b01: begin x = bw - 1 - v; y = u; end
               2'b10: begin x = bw - 1 - u; y = bh - 1 - v; end
               default: begin x = v; y = bh - 1 - u; end
            endcase
            if (mir) x = bw - 1 - x;
            e = comb(op, pat(sx + x, sy + y), pat(dx + i, dy + j));
            chk(mem_model_inst.mem[dx + i][dy + j], e);
         end
      bus_rd(`XF_OFS_PEN, rd);
      chk(rd, {16'(dy), 16'(dx)});
   endtask

   task automatic t_regs;
      bus_rd(`XF_OFS_BLK, rd);
      chk(rd, 32'h0);
      bus_rd(`XF_OFS_PEN, rd);
      chk(rd, 32'h0);
      bus_rd(5'h10, rd);
      chk(rd, 32'h0);
      // unknown opcode raises the sticky error, a one written to it clears it
      bus_wr(`XF_OFS_INSTR, 32'h00000000);
      bus_rd(`XF_OFS_STATUS, rd);
      chk(rd[`XF_ST_ERR], 1'b1);
      bus_wr(`XF_OFS_STATUS, 32'h00000002);
      bus_rd(`XF_OFS_STATUS, rd);
      chk(rd[`XF_ST_ERR], 1'b0);
   endtask
   task automatic t_full;
      bw = 3;
      bh = 2;
      xform(1'b1, 2'b01, 1'b0, 3'h0, '{16'd4, 16'd4, 16'd20, 16'd20, 16'd1, 16'd1},
         4, 4, 20, 20, 1, 1);
      bus_rd(`XF_OFS_STATUS, rd);
      chk(rd[`XF_ST_FULL], 1'b1);
   endtask
   task automatic t_cur;
      bw = 2;
      bh = 1;
      xform(1'b0, 2'b10, 1'b1, 3'h0, '{16'h0, 16'h0, 16'h400A, 16'h0, 16'd4, 16'd4},
         20, 20, 30, 20, 4, 4);
   endtask
   task automatic t_rel;
      bw = 2;
      bh = 2;
      slow <= 1'b1;
      xform(1'b1, 2'b11, 1'b1, 3'h3, '{16'h4002, 16'h4, 16'h4008, 16'h1, 16'd2, 16'd3},
         32, 24, 40, 25, 2, 3);
      slow <= 1'b0;
   endtask
   task automatic t_ops;
      // two-pixel mirrored row, so the plain mirror path is walked as well
      bw = 2;
      bh = 1;
      for (int op = 0; op < 8; op++)
         xform(1'b1, 2'b00, 1'b1, 3'(op), '{16'd1, 16'd1, 16'd50, 16'd50, 16'd1, 16'd1},
            1, 1, 50, 50, 1, 1);
   endtask

   task automatic wrap_up;
      $display("errors=%0d compares=%0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      repeat (80000) @(posedge clk);
      err_count++;
      wrap_up();
   end
   initial begin
      rst_n = 1'b0;
      slow = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      err_count = 0;
      cmp_count = 0;
      cyc = 0;
      rq_prev = 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_full();
      t_cur();
      t_rel();
      t_ops();
      wrap_up();
   end
endmodule
